//--- src/gtp_pkg.sv
// Shared constants, types and helpers of the general timer block.
// Assumes one clock domain and software access over AHB-Lite.
package gtp_pkg;

  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam int         NUM_TIMERS   = 5;           // Timers in the block.
  localparam logic [7:0] TIMER_STRIDE = 8'h10;       // Bytes per timer slot.
  localparam logic [7:0] OFS_CTRL     = 8'h00;       // Control word in a slot.
  localparam logic [7:0] OFS_PERIOD   = 8'h04;       // Period word in a slot.
  localparam logic [7:0] OFS_COUNT    = 8'h08;       // Count word in a slot.
  localparam logic [7:0] OFS_FLAGS    = 8'h50;       // Sticky event flags.
  localparam logic [7:0] OFS_ENABLE   = 8'h54;       // Interrupt enables.
  localparam logic [7:0] OFS_PRIORITY = 8'h58;       // Three bits per timer.
  localparam int BIT_RUN   = 15;                     // Run control.
  localparam int BIT_IDLE  = 13;                     // Idle stop select.
  localparam int BIT_GATE  = 6;                      // Gate accumulate enable.
  localparam int BIT_PS    = 4;                      // Prescale select, 2 bits.
  localparam int BIT_CHAIN = 3;                      // Pair chain select.
  localparam int BIT_SYNC  = 2;                      // Pin clock sync select.
  localparam int BIT_SRC   = 1;                      // Count source select.
  localparam logic [15:0] CTRL_RESET  = 16'h0000;    // Control reset value.
  localparam logic [15:0] PERIOD_RESET = 16'hffff;   // Period reset value.
  localparam logic [15:0] MASK_ALONE  = 16'ha076;    // Writable standalone bits.
  localparam logic [15:0] MASK_TYPEB  = 16'ha07a;    // Writable Type B bits.
  localparam logic [15:0] MASK_TYPEC  = 16'ha072;    // Writable Type C bits.

  // ****************************************
  // Prescaler terminal counts
  // ****************************************
  localparam logic [7:0] PS_LAST_1   = 8'h00;        // Divide by 1.
  localparam logic [7:0] PS_LAST_8   = 8'h07;        // Divide by 8.
  localparam logic [7:0] PS_LAST_64  = 8'h3f;        // Divide by 64.
  localparam logic [7:0] PS_LAST_256 = 8'hff;        // Divide by 256.

  // Kinds of timer, one-hot coded.
  typedef enum logic [2:0] {
    GTP_ALONE = 3'b001,
    GTP_TYPEB = 3'b010,
    GTP_TYPEC = 3'b100
  } gtp_kind_type;

  // Decoded control word.
  typedef struct packed {
    logic       run;
    logic       idle_stop;
    logic       gate_en;
    logic [1:0] prescale;
    logic       chain;
    logic       sync_sel;
    logic       source;
  } gtp_ctrl_type;

  // Overrides that a chained partner imposes on a timer.
  typedef struct packed {
    logic tick_en;
    logic tick;
    logic match_en;
    logic match;
  } gtp_chain_type;

  // Kind of the timer at each position.
  function automatic gtp_kind_type gtp_kind_of(input int idx);
    return (idx == 0) ? GTP_ALONE : ((idx % 2) == 1) ? GTP_TYPEB : GTP_TYPEC;
  endfunction

  // Unpacks a control word into its fields.
  function automatic gtp_ctrl_type gtp_unpack(input logic [15:0] w);
    return '{w[BIT_RUN], w[BIT_IDLE], w[BIT_GATE], w[BIT_PS+1:BIT_PS],
             w[BIT_CHAIN], w[BIT_SYNC], w[BIT_SRC]};
  endfunction

endpackage

//--- src/gtp_timer16.sv
// One 16-bit timer channel: source select, prescaler, pin sync, count.
// Assumes pins are synchronous to clock and overrides come from a partner.
`timescale 1ns/10ps
module gtp_timer16
  import gtp_pkg::*;
#(
  parameter gtp_kind_type KIND  = GTP_ALONE,  // Kind of this timer.
  parameter int           CNT_W = 16          // Count width.
)
(
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               clock_enable,
  input  wire logic               idle_mode,
  input  wire gtp_ctrl_type       ctrl,
  input  wire logic [CNT_W-1:0]   period,
  input  wire gtp_chain_type      chain,
  input  wire logic               cnt_wr,
  input  wire logic [CNT_W-1:0]   cnt_wdata,
  input  wire logic               ext_pin,
  input  wire logic               gate_pin,
  output logic [CNT_W-1:0]        count,
  output logic                    tick,
  output logic                    match_evt,
  output logic                    gate_evt
);

  // A count narrower than the prescaler makes no sense here.
  if (CNT_W < 8) begin : g_width_check
    $error("gtp_timer16: CNT_W must be at least 8");
  end

  logic             pin_raw, pin_raw_d;      // Registered pin for edges.
  logic             sync1, sync2, sync3;     // Pin synchroniser and edge stage.
  logic             gate_d;                  // Gate one cycle ago.
  logic [1:0]       post_sync;               // Sync stages after the prescaler.
  logic [7:0]       ps_cnt, next_ps;         // Prescaler counter.
  logic [CNT_W-1:0] next_cnt;                // Next count.
  logic             running, gate_mode, sync_after, pin_edge;
  logic             src_pulse, ps_fire, at_period;
  logic [7:0]       ps_last;

  // ****************************************
  // Tick generation and next count
  // ****************************************
  always_comb
  begin
    running    = ctrl.run & ~(ctrl.idle_stop & idle_mode);
    gate_mode  = ~ctrl.source & ctrl.gate_en;
    // Type B always syncs after the prescaler; standalone only on request.
    sync_after = (KIND == GTP_TYPEB) | ((KIND == GTP_ALONE) & ctrl.sync_sel);
    // Type C takes its edge from the synchronised pin, before prescaling.
    pin_edge   = (KIND == GTP_TYPEC) ? (sync2 & ~sync3) : (pin_raw & ~pin_raw_d);
    // The internal source pulses every cycle; the gate qualifies it.
    src_pulse  = ctrl.source ? pin_edge : (gate_mode ? gate_pin : 1'b1);
    case (ctrl.prescale)
      2'b11:   ps_last = PS_LAST_256;
      2'b10:   ps_last = PS_LAST_64;
      2'b01:   ps_last = PS_LAST_8;
      default: ps_last = PS_LAST_1;
    endcase
    ps_fire = running & src_pulse & (ps_cnt == ps_last);
    next_ps = running ? (src_pulse ? (ps_fire ? 8'h00 : ps_cnt + 8'h01) : ps_cnt) : 8'h00;
    if (chain.tick_en)
    begin
      tick = chain.tick;
    end
    else if (ctrl.source & sync_after)
    begin
      tick = post_sync[1] & running;
    end
    else
    begin
      tick = ps_fire;
    end
    at_period = chain.match_en ? chain.match : (count == period);
    match_evt = tick & at_period;
    gate_evt  = gate_mode & running & gate_d & ~gate_pin;
    if (cnt_wr)
    begin
      next_cnt = cnt_wdata;
    end
    else if (tick)
    begin
      next_cnt = at_period ? '0 : count + 1'b1;
    end
    else
    begin
      next_cnt = count;
    end
  end

  // Registers; a low clock enable freezes every stage.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      {pin_raw, pin_raw_d, sync1, sync2, sync3, gate_d} <= 6'h00;
      post_sync <= 2'h0;
      ps_cnt    <= 8'h00;
      count     <= '0;
    end
    else if (clock_enable)
    begin
      pin_raw   <= ext_pin;
      pin_raw_d <= pin_raw;
      sync1     <= ext_pin;
      sync2     <= sync1;
      sync3     <= sync2;
      gate_d    <= gate_pin;
      post_sync <= {post_sync[0], ps_fire};
      ps_cnt    <= next_ps;
      count     <= next_cnt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_period_wrap: assert property (clock_enable & match_evt & ~cnt_wr |=> count == '0)
    else $error("count did not clear after period match");
  a_count_step: assert property (clock_enable & tick & ~at_period & ~cnt_wr
    |=> count == $past(count) + 1'b1)
    else $error("count did not advance on tick");
  a_stopped_hold: assert property (clock_enable & ~ctrl.run & ~chain.tick_en & ~cnt_wr
    |=> $stable(count))
    else $error("count moved while stopped");
  a_idle_quiet: assert property (ctrl.idle_stop & idle_mode & ~chain.tick_en |-> ~tick)
    else $error("tick while stopped in idle");
  a_gate_blocks: assert property (gate_mode & ~gate_pin & ~chain.tick_en |-> ~tick)
    else $error("tick while gate low");
  c_gate_fall: cover property (gate_evt);
  c_wrap: cover property (match_evt & (period != '0));

endmodule

//--- src/gtp_timers.sv
// Five general timers with two 32-bit pairings, behind an AHB-Lite slave.
// Assumes a single clock that is also the instruction clock, synchronous pins.
//
// Overview of operation
// - Standalone mode from source, gate, sync bits.
// - Bit 13 stops the timer in idle.
// - Standalone bit 2 selects pin synchronisation.
// - Bit 1 picks pin clock or internal.
// - Type B syncs pin after prescaler.
// - Type C syncs pin before prescaler.
// - A Type C timer triggers conversions.
// - Types B and C lack asynchronous mode.
// - Only first B and C request DMA.
// - Chain bit joins B low, C high.
// - Chained pair obeys only B control; the code also ORs in the C idle stop bit.
// - Chained interrupts appear on the C timer.
// - Pairs are timers two-three and four-five.
// - Both count words readable at any time.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
module gtp_timers
  import gtp_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  clock_enable,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire logic                  idle_mode,
  input  wire logic                  standalone_ext_clock_pin,
  input  wire logic [3:0]            timer_ext_clock_pin,
  input  wire logic [NUM_TIMERS-1:0] gate_pin,
  output logic [NUM_TIMERS-1:0]      irq_request,
  output logic [14:0]                irq_priority,
  output logic [1:0]                 dma_request,
  output logic                       adc_trigger
);

  // ****************************************
  // Register state
  // ****************************************
  logic [15:0]           ctrl_reg   [NUM_TIMERS];    // Control words.
  logic [15:0]           next_ctrl  [NUM_TIMERS];
  logic [15:0]           period_reg [NUM_TIMERS];    // Period words.
  logic [15:0]           next_period[NUM_TIMERS];
  logic [NUM_TIMERS-1:0] flags, next_flags;          // Sticky event flags.
  logic [NUM_TIMERS-1:0] enable, next_enable;        // Interrupt enables.
  logic [14:0]           next_prio;                  // Priority field copy.
  logic                  dp_valid, next_dp_valid;    // Data phase pending.
  logic                  dp_write, next_dp_write;    // Data phase is a write.
  logic [7:0]            dp_addr, next_dp_addr;      // Data phase byte offset.
  logic [31:0]           next_hrdata;                // Read data for next phase.
  logic [1:0]            next_dma;
  logic                  next_adc;

  // ****************************************
  // Channel wiring
  // ****************************************
  logic [15:0]           count [NUM_TIMERS];         // Live counts.
  gtp_ctrl_type          eff_ctrl [NUM_TIMERS];      // Control as applied.
  gtp_chain_type         chain [NUM_TIMERS];         // Partner overrides.
  logic [NUM_TIMERS-1:0] tick, match_evt, gate_evt;
  logic [NUM_TIMERS-1:0] evt, period_pulse, cnt_wr;
  logic [NUM_TIMERS-1:0] pins;
  logic [1:0]            chained, full_match;

  assign pins = {timer_ext_clock_pin, standalone_ext_clock_pin};

  // Every channel is the same counter; only its kind differs.
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
    gtp_timer16 #(
      .KIND  (gtp_kind_of(i)),
      .CNT_W (16)
    ) u_timer (
      .clock        (clock),
      .rstn         (rstn),
      .clock_enable (clock_enable),
      .idle_mode    (idle_mode),
      .ctrl         (eff_ctrl[i]),
      .period       (period_reg[i]),
      .chain        (chain[i]),
      .cnt_wr       (cnt_wr[i]),
      .cnt_wdata    (hwdata[15:0]),
      .ext_pin      (pins[i]),
      .gate_pin     (gate_pin[i]),
      .count        (count[i]),
      .tick         (tick[i]),
      .match_evt    (match_evt[i]),
      .gate_evt     (gate_evt[i])
    );
  end

  // ****************************************
  // Pairing and event routing
  // ****************************************
  // Pairs are fixed: position 1 with 2 and 3 with 4, the lower one Type B.
  always_comb
  begin
    for (int t = 0; t < NUM_TIMERS; t++)
    begin
      eff_ctrl[t]     = gtp_unpack(ctrl_reg[t]);
      chain[t]        = '0;
      evt[t]          = match_evt[t] | gate_evt[t];
      period_pulse[t] = match_evt[t];
    end
    for (int p = 0; p < 2; p++)
    begin
      chained[p]    = ctrl_reg[2*p+1][BIT_CHAIN];
      full_match[p] = {count[2*p+2], count[2*p+1]}
                      == {period_reg[2*p+2], period_reg[2*p+1]};
      if (chained[p])
      begin
        // Either half may ask to stop in idle; the pair stops as one.
        eff_ctrl[2*p+1].idle_stop = ctrl_reg[2*p+1][BIT_IDLE] | ctrl_reg[2*p+2][BIT_IDLE];
        chain[2*p+1] = '{1'b0, 1'b0, 1'b1, full_match[p]};
        // The upper word steps on a lower carry and clears with the pair.
        chain[2*p+2] = '{1'b1, tick[2*p+1] & ((count[2*p+1] == 16'hffff)
                        | full_match[p]), 1'b1, full_match[p]};
        evt[2*p+2]          = match_evt[2*p+1] | gate_evt[2*p+1];
        evt[2*p+1]          = 1'b0;
        period_pulse[2*p+2] = match_evt[2*p+1];
        period_pulse[2*p+1] = 1'b0;
      end
    end
    next_dma = {period_pulse[2], period_pulse[1]};
    next_adc = period_pulse[2];
  end

  // ****************************************
  // Bus slave
  // ****************************************
  // Reads are looked up in the address phase so the data phase never waits.
  always_comb
  begin
    // Only the low 256 bytes are mapped; a write further up must not alias.
    next_dp_valid = hsel & htrans[1] & hready & (haddr[31:8] == 24'h00_0000);
    next_dp_write = hwrite;
    next_dp_addr  = {haddr[7:2], 2'b00};
    next_hrdata   = 32'h0000_0000;
    if (!(next_dp_valid & ~hwrite) || (haddr[31:8] != 24'h00_0000))
    begin
      next_hrdata = 32'h0000_0000;
    end
    else if (next_dp_addr == OFS_FLAGS)
    begin
      next_hrdata = {27'h000_0000, flags};
    end
    else if (next_dp_addr == OFS_ENABLE)
    begin
      next_hrdata = {27'h000_0000, enable};
    end
    else if (next_dp_addr == OFS_PRIORITY)
    begin
      next_hrdata = {17'h0_0000, irq_priority};
    end
    else
    begin
      for (int t = 0; t < NUM_TIMERS; t++)
      begin
        if (next_dp_addr == 8'(t * TIMER_STRIDE) + OFS_CTRL)
        begin
          next_hrdata = {16'h0000, ctrl_reg[t]};
        end
        else if (next_dp_addr == 8'(t * TIMER_STRIDE) + OFS_PERIOD)
        begin
          next_hrdata = {16'h0000, period_reg[t]};
        end
        else if (next_dp_addr == 8'(t * TIMER_STRIDE) + OFS_COUNT)
        begin
          next_hrdata = {16'h0000, count[t]};
        end
      end
    end
  end

  // Writes land in the data phase; flags clear by writing ones.
  always_comb
  begin
    next_ctrl   = ctrl_reg;
    next_period = period_reg;
    next_enable = enable;
    next_prio   = irq_priority;
    cnt_wr      = '0;
    next_flags  = flags;
    if (dp_valid & dp_write)
    begin
      if (dp_addr == OFS_FLAGS)
      begin
        next_flags = flags & ~hwdata[NUM_TIMERS-1:0];
      end
      else if (dp_addr == OFS_ENABLE)
      begin
        next_enable = hwdata[NUM_TIMERS-1:0];
      end
      else if (dp_addr == OFS_PRIORITY)
      begin
        next_prio = hwdata[14:0];
      end
      else
      begin
        for (int t = 0; t < NUM_TIMERS; t++)
        begin
          if (dp_addr == 8'(t * TIMER_STRIDE) + OFS_CTRL)
          begin
            // Unimplemented bits stay zero; Type B and C have no sync bit.
            next_ctrl[t] = hwdata[15:0] & ((t == 0) ? MASK_ALONE :
                           (t % 2 == 1) ? MASK_TYPEB : MASK_TYPEC);
          end
          else if (dp_addr == 8'(t * TIMER_STRIDE) + OFS_PERIOD)
          begin
            next_period[t] = hwdata[15:0];
          end
          else if (dp_addr == 8'(t * TIMER_STRIDE) + OFS_COUNT)
          begin
            cnt_wr[t] = 1'b1;
          end
        end
      end
    end
    // An event in the same cycle as its clear keeps the flag set.
    next_flags = next_flags | evt;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int t = 0; t < NUM_TIMERS; t++)
      begin
        ctrl_reg[t]   <= CTRL_RESET;
        period_reg[t] <= PERIOD_RESET;
      end
      flags        <= '0;
      enable       <= '0;
      irq_priority <= 15'h0000;
      dp_valid     <= 1'b0;
      dp_write     <= 1'b0;
      dp_addr      <= 8'h00;
      hrdata       <= 32'h0000_0000;
      dma_request  <= 2'h0;
      adc_trigger  <= 1'b0;
    end
    else if (clock_enable)
    begin
      ctrl_reg     <= next_ctrl;
      period_reg   <= next_period;
      flags        <= next_flags;
      enable       <= next_enable;
      irq_priority <= next_prio;
      dp_valid     <= next_dp_valid;
      dp_write     <= next_dp_write;
      dp_addr      <= next_dp_addr;
      hrdata       <= next_hrdata;
      dma_request  <= next_dma;
      adc_trigger  <= next_adc;
    end
  end

  // The slave never stalls and never reports an error.
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign irq_request = flags & enable;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_flag_set_wins: assert property (clock_enable & (|evt)
    |=> (flags & $past(evt)) == $past(evt))
    else $error("event flag lost");
  a_chain_irq_upper: assert property (clock_enable & chained[0] & match_evt[1]
    |=> flags[2])
    else $error("chained match not flagged on upper timer");
  a_chain_carry: assert property (clock_enable & chained[0] & tick[1] & ~full_match[0]
    & (count[1] == 16'hffff) & ~cnt_wr[2] |=> count[2] == $past(count[2]) + 16'h0001)
    else $error("upper word missed the carry");
  a_dma_pulse: assert property (clock_enable & period_pulse[1] |=> dma_request[0])
    else $error("dma request missing");
  a_adc_trigger: assert property (clock_enable & period_pulse[2] |=> adc_trigger)
    else $error("conversion trigger missing");
  c_chain_wrap: cover property (chained[0] & match_evt[1]);
  c_second_pair: cover property (chained[1] & tick[3] & (count[3] == 16'hffff));
  c_dma: cover property (dma_request[0] ##1 dma_request[1]);

endmodule

//--- tb/gtp_timers_tb.sv
// Self-checking bench of the five-timer block.
// Assumes one 20 MHz clock and a bus slave that answers at once.
`timescale 1ns/10ps
module gtp_timers_tb;
  import gtp_pkg::*;
  logic        clock;
  logic        rstn;
  logic        ce;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        idle_mode;
  logic        s_pin;
  logic [3:0]  x_pin;
  logic [4:0]  gate;
  logic [4:0]  irq;
  logic [14:0] prio;
  logic [1:0]  dma;
  logic        adc;
  int          err_total;
  int          n_compared;
  int          n_adc;
  int          n_dma0;
  int          n_dma1;
  // Clock of 50 ns period.
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  gtp_timers dut_u (.clock(clock), .rstn(rstn), .clock_enable(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .idle_mode(idle_mode), .standalone_ext_clock_pin(s_pin), .timer_ext_clock_pin(x_pin),
    .gate_pin(gate), .irq_request(irq), .irq_priority(prio), .dma_request(dma),
    .adc_trigger(adc));
  // Pulse counters of the one-cycle event outputs.
  always @(posedge clock)
  begin
    n_adc  += (adc === 1'b1);
    n_dma0 += (dma[0] === 1'b1);
    n_dma1 += (dma[1] === 1'b1);
  end
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for an edge with hready high; a bound stops a hung slave.
  task automatic ready_edge();
    int w;
    w = 0;
    do @(posedge clock); while (hreadyout !== 1'b1 && ++w < 50);
    if (w >= 50)
    begin
      err_total++;
      conclude();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    ready_edge();
    htrans <= 2'h0;
    hwdata <= d;
    ready_edge();
    rd = hrdata;
  endtask
  task automatic rcheck(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic in_range(input logic [31:0] a, input int lo, input int hi);
    bus(1'b0, a, 32'h0);
    check({31'h0, (rd >= lo && rd <= hi)}, 32'h1);
  endtask
  // Reset values, writable masks, unmapped places and the priority port.
  task automatic t_regs();
    logic [15:0] m [3];
    m = '{MASK_ALONE, MASK_TYPEB, MASK_TYPEC};
    for (int t = 0; t < 3; t++)
    begin
      rcheck(32'h10 * t, 32'h0);
      rcheck(32'h10 * t + 4, 32'hffff);
      bus(1'b1, 32'h10 * t, 32'hffff);
      rcheck(32'h10 * t, {16'h0, m[t]});
      bus(1'b1, 32'h10 * t, 32'h0);
    end
    bus(1'b1, 32'h5c, 32'h1234);
    rcheck(32'h5c, 32'h0);
    rcheck(32'h100, 32'h0);
    bus(1'b1, 32'h100, 32'h8000);
    rcheck(32'h0, 32'h0);
    bus(1'b1, 32'h58, 32'h7fff);
    @(posedge clock);
    check({17'h0, prio}, 32'h7fff);
  endtask
  // Each prescale code over 512 clocks, then the count holds while stopped.
  task automatic t_prescale();
    int d [4];
    d = '{1, 8, 64, 256};
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 32'h8, 32'h0);
      bus(1'b1, 32'h0, 32'h8000 | (k << 4));
      repeat (512) @(posedge clock);
      bus(1'b1, 32'h0, 32'h0);
      in_range(32'h8, 512 / d[k], 520 / d[k] + 1);
      rcheck(32'h8, rd);
    end
  endtask
  // Period match wraps the count and raises the flag.
  task automatic t_period();
    int w;
    bus(1'b1, 32'h8, 32'h0);
    bus(1'b1, 32'h4, 32'h3);
    bus(1'b1, 32'h54, 32'h1f);
    bus(1'b1, 32'h0, 32'h8000);
    w = 0;
    while (irq[0] !== 1'b1 && ++w < 100) @(posedge clock);
    check({31'h0, irq[0]}, 32'h1);
    in_range(32'h8, 0, 3);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'h50, 32'h1f);
    rcheck(32'h50, 32'h0);
    bus(1'b1, 32'h4, 32'hffff);
  endtask
  // Idle stop bit freezes the count only when set.
  task automatic t_idle();
    bus(1'b1, 32'h8, 32'h0);
    idle_mode <= 1'b1;
    bus(1'b1, 32'h0, 32'ha000);
    repeat (50) @(posedge clock);
    rcheck(32'h8, 32'h0);
    bus(1'b1, 32'h0, 32'h8000);
    repeat (50) @(posedge clock);
    bus(1'b1, 32'h0, 32'h0);
    in_range(32'h8, 48, 60);
    idle_mode <= 1'b0;
  endtask
  // A low clock enable freezes the running count.
  task automatic t_freeze();
    bus(1'b1, 32'h8, 32'h0);
    bus(1'b1, 32'h0, 32'h8000);
    ce <= 1'b0;
    repeat (30) @(posedge clock);
    ce <= 1'b1;
    bus(1'b1, 32'h0, 32'h0);
    rcheck(32'h8, 32'h3);
  endtask
  // Gated counting on timer 1; the falling gate sets its flag.
  task automatic t_gate();
    bus(1'b1, 32'h18, 32'h0);
    bus(1'b1, 32'h10, 32'h8040);
    repeat (40) @(posedge clock);
    rcheck(32'h18, 32'h0);
    gate[1] <= 1'b1;
    repeat (40) @(posedge clock);
    gate[1] <= 1'b0;
    repeat (4) @(posedge clock);
    bus(1'b1, 32'h10, 32'h0);
    in_range(32'h18, 38, 44);
    rcheck(32'h50, 32'h2);
    bus(1'b1, 32'h50, 32'h1f);
  endtask
  // Ten pin edges on timer 0 unsynchronised and synchronised, then on
  // timers 1 and 2, each with the gate bit set and gate low.
  task automatic t_ext();
    logic [15:0] c [4];
    int          u;
    c = '{16'h8002, 16'h8006, 16'h8046, 16'h8042};
    for (int t = 0; t < 4; t++)
    begin
      u = (t == 0) ? 0 : t - 1;
      bus(1'b1, 32'h10 * u + 8, 32'h0);
      bus(1'b1, 32'h10 * u, {16'h0, c[t]});
      for (int p = 0; p < 10; p++)
      begin
        @(posedge clock);
        s_pin <= (u == 0);
        x_pin <= (u == 0) ? 4'h0 : 4'h1 << (u - 1);
        repeat (4) @(posedge clock);
        s_pin <= 1'b0;
        x_pin <= 4'h0;
        repeat (4) @(posedge clock);
      end
      repeat (6) @(posedge clock);
      rcheck(32'h10 * u + 8, 32'ha);
      bus(1'b1, 32'h10 * u, 32'h0);
    end
  endtask
  // Timers 1 and 2 chained: carry into the upper word, events on the upper half.
  task automatic t_chain();
    int w;
    bus(1'b1, 32'h18, 32'hfffe);
    bus(1'b1, 32'h28, 32'h0);
    bus(1'b1, 32'h20, 32'h0002);
    bus(1'b1, 32'h10, 32'h8008);
    repeat (10) @(posedge clock);
    bus(1'b1, 32'h10, 32'h0);
    rcheck(32'h28, 32'h1);
    in_range(32'h18, 8, 16);
    bus(1'b1, 32'h18, 32'h0);
    bus(1'b1, 32'h28, 32'h0);
    bus(1'b1, 32'h14, 32'h4);
    bus(1'b1, 32'h24, 32'h0);
    bus(1'b1, 32'h50, 32'h1f);
    {n_adc, n_dma0, n_dma1} = '0;
    bus(1'b1, 32'h10, 32'h8008);
    w = 0;
    while (irq[2] !== 1'b1 && ++w < 100) @(posedge clock);
    repeat (20) @(posedge clock);
    bus(1'b1, 32'h10, 32'h0);
    check({30'h0, irq[2:1]}, 32'h2);
    check({31'h0, n_adc > 0}, 32'h1);
    check({31'h0, n_dma1 > 0 && n_dma0 == 0}, 32'h1);
    bus(1'b1, 32'h38, 32'hffff);
    bus(1'b1, 32'h48, 32'h0);
    bus(1'b1, 32'h30, 32'h8008);
    bus(1'b1, 32'h30, 32'h0);
    rcheck(32'h48, 32'h1);
  endtask
  initial
  begin
    {rstn, hsel, hwrite, htrans, haddr, hwdata, idle_mode, s_pin, x_pin, gate} = '0;
    {err_total, n_compared, n_adc, n_dma0, n_dma1} = '0;
    ce = 1'b1;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_prescale();
    t_period();
    t_idle();
    t_freeze();
    t_gate();
    t_ext();
    t_chain();
    conclude();
  end
endmodule
